//--- hdl/asf_pkg.sv
package asf_pkg;

  // ----------------------------------------------------------------
  // Register indices and APB byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ASF_IDX_FLAGS_COPY = 32'h0000_3880;
  localparam int unsigned ASF_IDX_WORK_COPY  = 32'h0000_3881;
  localparam int unsigned ASF_IDX_BANK_COPY  = 32'h0000_3882;
  localparam int unsigned ASF_IDX_FLAG_REG   = 32'h0000_3884;
  localparam int unsigned ASF_IDX_CTRL       = 32'h0000_3888;

  localparam logic [15:0] ASF_ADR_FLAGS_COPY = 16'(ASF_IDX_FLAGS_COPY * 4);
  localparam logic [15:0] ASF_ADR_WORK_COPY  = 16'(ASF_IDX_WORK_COPY * 4);
  localparam logic [15:0] ASF_ADR_BANK_COPY  = 16'(ASF_IDX_BANK_COPY * 4);
  localparam logic [15:0] ASF_ADR_FLAG_REG   = 16'(ASF_IDX_FLAG_REG * 4);
  localparam logic [15:0] ASF_ADR_CTRL       = 16'(ASF_IDX_CTRL * 4);

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [4:0] ASF_ARITH_RESET  = 5'h00;
  localparam logic       ASF_WDOG_RESET   = 1'b1;
  localparam logic       ASF_PDOWN_RESET  = 1'b1;
  localparam logic       ASF_XSET_RESET   = 1'b0;
  localparam int         ASF_XSET_BIT     = 0;
  localparam int         ASF_POS_CARRY    = 0;
  localparam int         ASF_POS_HALF     = 1;
  localparam int         ASF_POS_ZERO     = 2;
  localparam int         ASF_POS_WRAP     = 3;
  localparam int         ASF_POS_NEG      = 4;

  // Call copy slots
  localparam logic [1:0] ASF_SLOT_FLAGS = 2'h0;
  localparam logic [1:0] ASF_SLOT_WORK  = 2'h1;
  localparam logic [1:0] ASF_SLOT_BANK  = 2'h2;
  localparam int         ASF_SLOTS      = 3;

  // ----------------------------------------------------------------
  // Instruction kinds and carriers
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ASF_K_NOP   = 4'h0,
    ASF_K_ADD   = 4'h1,
    ASF_K_SUB   = 4'h2,
    ASF_K_AND   = 4'h3,
    ASF_K_IOR   = 4'h4,
    ASF_K_XOR   = 4'h5,
    ASF_K_RLC   = 4'h6,
    ASF_K_RRC   = 4'h7,
    ASF_K_CLR   = 4'h8,
    ASF_K_KEEP  = 4'h9,
    ASF_K_WDCLR = 4'hA,
    ASF_K_SLEEP = 4'hB,
    ASF_K_CALL  = 4'hC
  } asf_kind_type;

  typedef struct packed {
    logic         valid;
    asf_kind_type kind;
    logic [7:0]   opA;
    logic [7:0]   opB;
    logic         toFlags;
  } asf_op_type;

endpackage

//--- hdl/asf_call_copy_mem.sv
`timescale 1ns/1ps
module asf_call_copy_mem (
  input  wire logic                             clk,     // System clock
  input  wire logic                             reset,   // Sync reset
  input  wire logic                             capture, // Call taken
  input  wire logic [asf_pkg::ASF_SLOTS-1:0][7:0] capData, // Call values
  input  wire logic                             wrEn,    // Software write
  input  wire logic [1:0]                       wrIdx,   // Write slot
  input  wire logic [7:0]                       wrData,  // Write byte
  input  wire logic [1:0]                       rdIdx,   // Read slot
  output logic      [7:0]                       rdData   // Read byte
);

  logic [7:0] slot_ff [asf_pkg::ASF_SLOTS];
  logic [7:0] rdData_ff;

  // ----------------------------------------------------------------
  // Slots: call capture beats a software write in the same cycle
  // ----------------------------------------------------------------
  for (genvar e = 0; e < asf_pkg::ASF_SLOTS; e++) begin : g_slot
    always_ff @(posedge clk) begin
      if (reset) begin
        slot_ff[e] <= 8'h00;
      end else if (capture) begin
        slot_ff[e] <= capData[e]; // [RULE_13]
      end else if (wrEn && wrIdx == 2'(e)) begin
        slot_ff[e] <= wrData; // [RULE_16]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_ff <= 8'h00;
    end else if (rdIdx < 2'(asf_pkg::ASF_SLOTS)) begin
      rdData_ff <= slot_ff[rdIdx];
    end else begin
      rdData_ff <= 8'h00;
    end
  end

  assign rdData = rdData_ff;

  capTake_a: assert property (@(posedge clk) disable iff (reset) // [RULE_13]
    capture |=> slot_ff[0] == $past(capData[0])
            && slot_ff[2] == $past(capData[2]))
    else $error("call copy not captured");

  slotHold_a: assert property (@(posedge clk) disable iff (reset) // [RULE_16]
    (!capture && !wrEn) |=> $stable(slot_ff[1]) && $stable(slot_ff[0]))
    else $error("call copy changed without cause");

endmodule // asf_call_copy_mem

//--- hdl/asf_flag_unit.sv
`timescale 1ns/1ps
// What this block does
// [RULE_01] Bit 7 of the flag register is absent and reads zero.
// [RULE_02] Expiry sets on power-up, watchdog clear, sleep; timeout clears.
// [RULE_03] Power-down sets at power-up or watchdog clear and clears on sleep.
// [RULE_04] Negative follows the result's top bit.
// [RULE_05] Signed wrap sets when seven-bit overflow flips the sign bit.
// [RULE_06] Zero sets when an arithmetic or logic result is zero, else clears.
// [RULE_07] Add and subtract set half carry on carry out of bit 3.
// [RULE_08] Add and subtract set carry on carry out of bit 7.
// [RULE_09] Subtract adds the two's complement; carries are inverted borrows.
// [RULE_10] Rotate through carry loads carry with the bit shifted out.
// [RULE_11] A flag-affecting op aimed at the flag register drops its result.
// [RULE_12] Move, bit and swap ops leave the five arithmetic flags alone.
// [RULE_13] A call saves working, bank select and flags into readable copies.
// [RULE_14] Indexed literal offset mode needs the extended set bit at one.
// [RULE_15] Unmapped locations read as zero.
// [RULE_16] A call copy changes only on the next call or a software write.
module asf_flag_unit (
  input  wire logic               clk,        // System clock, 10 MHz
  input  wire logic               reset,      // Sync reset, power-up
  input  wire logic               psel,       // APB select
  input  wire logic               penable,    // APB enable
  input  wire logic               pwrite,     // APB write
  input  wire logic [15:0]        paddr,      // APB byte address
  input  wire logic [31:0]        pwdata,     // APB write data
  input  wire logic [3:0]         pstrb,      // APB byte strobes
  output logic      [31:0]        prdata,     // APB read data
  output logic                    pready,     // APB ready
  output logic                    pslverr,    // APB error, always low
  input  wire asf_pkg::asf_op_type opIn,      // Executing instruction
  input  wire logic [7:0]         workReg,    // Working register now
  input  wire logic [7:0]         bankSel,    // Bank select now
  input  wire logic               wdogTimeout, // Watchdog timeout pulse
  output logic      [7:0]         resultOut,  // Instruction result
  output logic                    resultValid, // Result to write back
  output logic      [7:0]         flagsOut,   // Flag register value
  output logic                    indexedLitOffsetEn // Extended mode on
);

  default clocking dcb @(posedge clk); endclocking
  default disable iff (reset);

  logic [4:0]  arithFlags_ff;
  logic [4:0]  nxt_arithFlags;
  logic        wdogExpiry_ff;
  logic        powerdown_ff;
  logic        extSetEnable_ff;
  logic [7:0]  resultOut_ff;
  logic        resultValid_ff;
  logic [7:0]  flagByte;
  logic [7:0]  addend;
  logic        carryIn;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic        wrapOut;
  logic [7:0]  aluRes;
  logic        updZ;
  logic        updN;
  logic        updArith;
  logic        updRot;
  logic        rotCarry;
  logic        makesResult;
  logic        setupPh;
  logic        wrAcc;
  logic        apbWrFlag;
  logic        apbWrCtrl;
  logic        copyHit;
  logic [1:0]  copyIdx;
  logic        memSel_ff;
  logic [31:0] localRd_ff;
  logic [7:0]  memRd;
  logic        isCall;

  // ----------------------------------------------------------------
  // Adder: subtraction adds the inverted operand plus one
  // ----------------------------------------------------------------
  always_comb begin
    addend  = opIn.opB;
    carryIn = 1'b0;
    if (opIn.kind == asf_pkg::ASF_K_SUB) begin
      addend  = ~opIn.opB; // [RULE_09]
      carryIn = 1'b1;
    end
  end

  assign sum9 = {1'b0, opIn.opA} + {1'b0, addend} + {8'h00, carryIn};
  assign sum5 = {1'b0, opIn.opA[3:0]} + {1'b0, addend[3:0]}
              + {4'h0, carryIn};
  assign wrapOut = (opIn.opA[7] == addend[7])
                && (sum9[7] != opIn.opA[7]); // [RULE_05]

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  always_comb begin
    aluRes      = 8'h00;
    updZ        = 1'b0;
    updN        = 1'b0;
    updArith    = 1'b0;
    updRot      = 1'b0;
    rotCarry    = 1'b0;
    makesResult = 1'b1;
    case (opIn.kind)
      asf_pkg::ASF_K_ADD, asf_pkg::ASF_K_SUB: begin
        aluRes   = sum9[7:0];
        updZ     = 1'b1;
        updN     = 1'b1;
        updArith = 1'b1;
      end
      asf_pkg::ASF_K_AND: begin
        aluRes = opIn.opA & opIn.opB;
        updZ   = 1'b1;
        updN   = 1'b1;
      end
      asf_pkg::ASF_K_IOR: begin
        aluRes = opIn.opA | opIn.opB;
        updZ   = 1'b1;
        updN   = 1'b1;
      end
      asf_pkg::ASF_K_XOR: begin
        aluRes = opIn.opA ^ opIn.opB;
        updZ   = 1'b1;
        updN   = 1'b1;
      end
      asf_pkg::ASF_K_RLC: begin
        aluRes   = {opIn.opA[6:0], arithFlags_ff[asf_pkg::ASF_POS_CARRY]};
        rotCarry = opIn.opA[7]; // [RULE_10]
        updRot   = 1'b1;
        updZ     = 1'b1;
        updN     = 1'b1;
      end
      asf_pkg::ASF_K_RRC: begin
        aluRes   = {arithFlags_ff[asf_pkg::ASF_POS_CARRY], opIn.opA[7:1]};
        rotCarry = opIn.opA[0]; // [RULE_10]
        updRot   = 1'b1;
        updZ     = 1'b1;
        updN     = 1'b1;
      end
      asf_pkg::ASF_K_CLR: begin
        aluRes = 8'h00;
        updZ   = 1'b1;
      end
      asf_pkg::ASF_K_KEEP: begin
        aluRes = opIn.opB; // [RULE_12]
      end
      default: begin
        makesResult = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Arithmetic flags: instruction beats a software write
  // ----------------------------------------------------------------
  always_comb begin
    nxt_arithFlags = arithFlags_ff;
    if (apbWrFlag) begin
      nxt_arithFlags = pwdata[4:0];
    end
    if (opIn.valid) begin
      if (opIn.kind == asf_pkg::ASF_K_KEEP && opIn.toFlags) begin
        nxt_arithFlags = aluRes[4:0];
      end
      if (updZ) begin
        nxt_arithFlags[asf_pkg::ASF_POS_ZERO] = (aluRes == 8'h00); // [RULE_06]
      end
      if (updN) begin
        nxt_arithFlags[asf_pkg::ASF_POS_NEG] = aluRes[7]; // [RULE_04]
      end
      if (updArith) begin
        nxt_arithFlags[asf_pkg::ASF_POS_WRAP]  = wrapOut; // [RULE_05]
        nxt_arithFlags[asf_pkg::ASF_POS_HALF]  = sum5[4]; // [RULE_07]
        nxt_arithFlags[asf_pkg::ASF_POS_CARRY] = sum9[8]; // [RULE_08]
      end
      if (updRot) begin
        nxt_arithFlags[asf_pkg::ASF_POS_CARRY] = rotCarry; // [RULE_10]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      arithFlags_ff <= asf_pkg::ASF_ARITH_RESET;
    end else begin
      arithFlags_ff <= nxt_arithFlags;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog expiry and power-down; sets win over clears
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wdogExpiry_ff <= asf_pkg::ASF_WDOG_RESET;
    end else if (opIn.valid && (opIn.kind == asf_pkg::ASF_K_WDCLR
                 || opIn.kind == asf_pkg::ASF_K_SLEEP)) begin
      wdogExpiry_ff <= 1'b1; // [RULE_02]
    end else if (wdogTimeout) begin
      wdogExpiry_ff <= 1'b0; // [RULE_02]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      powerdown_ff <= asf_pkg::ASF_PDOWN_RESET;
    end else if (opIn.valid && opIn.kind == asf_pkg::ASF_K_WDCLR) begin
      powerdown_ff <= 1'b1; // [RULE_03]
    end else if (opIn.valid && opIn.kind == asf_pkg::ASF_K_SLEEP) begin
      powerdown_ff <= 1'b0; // [RULE_03]
    end
  end

  assign flagByte = {1'b0, wdogExpiry_ff, powerdown_ff,
                     arithFlags_ff}; // [RULE_01]
  assign flagsOut = flagByte;

  // ----------------------------------------------------------------
  // Result write-back; results aimed at the flags are dropped
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      resultOut_ff   <= 8'h00;
      resultValid_ff <= 1'b0;
    end else begin
      resultValid_ff <= opIn.valid && makesResult
                     && !opIn.toFlags; // [RULE_11]
      if (opIn.valid && makesResult) begin
        resultOut_ff <= aluRes;
      end
    end
  end

  assign resultOut   = resultOut_ff;
  assign resultValid = resultValid_ff;

  // ----------------------------------------------------------------
  // APB slave: zero wait states, reads sampled in the setup cycle
  // ----------------------------------------------------------------
  assign setupPh   = psel && !penable;
  assign pready    = psel && penable;
  assign pslverr   = 1'b0;
  assign wrAcc     = psel && penable && pwrite && pstrb[0];
  assign apbWrFlag = wrAcc && paddr == asf_pkg::ASF_ADR_FLAG_REG;
  assign apbWrCtrl = wrAcc && paddr == asf_pkg::ASF_ADR_CTRL;

  always_comb begin
    copyHit = 1'b1;
    copyIdx = asf_pkg::ASF_SLOT_FLAGS;
    case (paddr)
      asf_pkg::ASF_ADR_FLAGS_COPY: copyIdx = asf_pkg::ASF_SLOT_FLAGS;
      asf_pkg::ASF_ADR_WORK_COPY:  copyIdx = asf_pkg::ASF_SLOT_WORK;
      asf_pkg::ASF_ADR_BANK_COPY:  copyIdx = asf_pkg::ASF_SLOT_BANK;
      default:                     copyHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      extSetEnable_ff <= asf_pkg::ASF_XSET_RESET;
    end else if (apbWrCtrl) begin
      extSetEnable_ff <= pwdata[asf_pkg::ASF_XSET_BIT];
    end
  end

  assign indexedLitOffsetEn = extSetEnable_ff; // [RULE_14]

  always_ff @(posedge clk) begin
    if (reset) begin
      localRd_ff <= 32'h0000_0000;
      memSel_ff  <= 1'b0;
    end else if (setupPh) begin
      memSel_ff <= copyHit;
      case (paddr)
        asf_pkg::ASF_ADR_FLAG_REG: localRd_ff <= {24'h00_0000, flagByte};
        asf_pkg::ASF_ADR_CTRL:     localRd_ff <= {31'h0000_0000,
                                                  extSetEnable_ff};
        default:                   localRd_ff <= 32'h0000_0000; // [RULE_15]
      endcase
    end
  end

  assign prdata = memSel_ff ? {24'h00_0000, memRd} : localRd_ff;

  // ----------------------------------------------------------------
  // Call copies
  // ----------------------------------------------------------------
  assign isCall = opIn.valid && opIn.kind == asf_pkg::ASF_K_CALL;

  asf_call_copy_mem u_copy (
    .clk     (clk),
    .reset   (reset),
    .capture (isCall), // [RULE_13]
    .capData ({bankSel, workReg, flagByte}),
    .wrEn    (wrAcc && copyHit), // [RULE_16]
    .wrIdx   (copyIdx),
    .wrData  (pwdata[7:0]),
    .rdIdx   (copyIdx),
    .rdData  (memRd)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence flagRead;
    setupPh && !pwrite && paddr == asf_pkg::ASF_ADR_FLAG_REG;
  endsequence

  sequence holeRead;
    setupPh && !pwrite && !copyHit && paddr != asf_pkg::ASF_ADR_FLAG_REG
    && paddr != asf_pkg::ASF_ADR_CTRL;
  endsequence

  msbZero_a: assert property ( // [RULE_01]
    flagRead ##1 pready |-> prdata[31:7] == 25'h000_0000)
    else $error("flag bit 7 read as one");

  holeZero_a: assert property ( // [RULE_15]
    holeRead ##1 pready |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  wdogSet_a: assert property ( // [RULE_02]
    (opIn.valid && opIn.kind inside {asf_pkg::ASF_K_WDCLR,
     asf_pkg::ASF_K_SLEEP}) |=> wdogExpiry_ff)
    else $error("expiry flag not set");

  wdogClr_a: assert property ( // [RULE_02]
    (wdogTimeout && !(opIn.valid && opIn.kind inside
     {asf_pkg::ASF_K_WDCLR, asf_pkg::ASF_K_SLEEP})) |=> !wdogExpiry_ff)
    else $error("expiry flag not cleared");

  pdSleep_a: assert property ( // [RULE_03]
    (opIn.valid && opIn.kind == asf_pkg::ASF_K_SLEEP)
    |=> !powerdown_ff && wdogExpiry_ff)
    else $error("sleep flags wrong");

  andFlags_a: assert property ( // [RULE_04]
    (opIn.valid && opIn.kind == asf_pkg::ASF_K_AND && !opIn.toFlags)
    |=> arithFlags_ff[4] == resultOut_ff[7]
     && arithFlags_ff[2] == (resultOut_ff == 8'h00))
    else $error("logic flags wrong");

  addCarry_a: assert property ( // [RULE_08]
    (opIn.valid && opIn.kind == asf_pkg::ASF_K_ADD)
    |=> arithFlags_ff[0] == (({1'b0, $past(opIn.opA)}
        + {1'b0, $past(opIn.opB)}) > 9'h0FF)
     && arithFlags_ff[1] == (({1'b0, $past(opIn.opA[3:0])}
        + {1'b0, $past(opIn.opB[3:0])}) > 5'h0F))
    else $error("add carries wrong");

  subBorrow_a: assert property ( // [RULE_09]
    (opIn.valid && opIn.kind == asf_pkg::ASF_K_SUB)
    |=> arithFlags_ff[0] == ($past(opIn.opA) >= $past(opIn.opB)))
    else $error("borrow polarity wrong");

  addWrap_a: assert property ( // [RULE_05]
    (opIn.valid && opIn.kind == asf_pkg::ASF_K_ADD && !opIn.toFlags)
    |=> arithFlags_ff[3] == ($past(opIn.opA[7]) == $past(opIn.opB[7])
        && $past(opIn.opA[7]) != resultOut_ff[7]))
    else $error("signed wrap wrong");

  rotLeft_a: assert property ( // [RULE_10]
    (opIn.valid && opIn.kind == asf_pkg::ASF_K_RLC)
    |=> arithFlags_ff[0] == $past(opIn.opA[7]))
    else $error("rotate carry wrong");

  clrDrop_a: assert property ( // [RULE_11]
    (opIn.valid && opIn.toFlags && opIn.kind == asf_pkg::ASF_K_CLR
     && !apbWrFlag)
    |=> !resultValid_ff && arithFlags_ff == {$past(arithFlags_ff[4:3]),
        1'b1, $past(arithFlags_ff[1:0])})
    else $error("clear of flags wrong");

  keepFlags_a: assert property ( // [RULE_12]
    (opIn.valid && opIn.kind == asf_pkg::ASF_K_KEEP && !opIn.toFlags
     && !apbWrFlag) |=> $stable(arithFlags_ff))
    else $error("move changed flags");

  xsetWr_a: assert property ( // [RULE_14]
    apbWrCtrl |=> indexedLitOffsetEn == $past(pwdata[0]))
    else $error("extended enable not written");

endmodule // asf_flag_unit

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic                clk = 1'b0;
  logic                reset = 1'b1;
  logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0]         paddr = 16'h0000;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [3:0]          pstrb = 4'hF;
  logic [31:0]         prdata;
  logic                pready, pslverr, resultValid, litEn;
  asf_pkg::asf_op_type opIn = '0;
  logic [7:0]          workReg = 8'hA5, bankSel = 8'h3C;
  logic                wdogTimeout = 1'b0;
  logic [7:0]          resultOut, flagsOut, rnd = 8'h1F, cp[3];
  logic                mW = 1'b1, mP = 1'b1;
  logic [4:0]          mA = 5'h00;
  logic [31:0]         rd;
  logic [15:0]         cpAdr[3];
  logic [7:0]          va[5] = '{8'h7F, 8'hFF, 8'h80, 8'h0F, 8'h00};
  logic [7:0]          vb[5] = '{8'h01, 8'h01, 8'h80, 8'h01, 8'h00};
  int                  fail_count = 0, total_checks = 0;

  always #50 clk = ~clk;

  asf_flag_unit asf_flag_unit_inst (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opIn(opIn), .workReg(workReg), .bankSel(bankSel),
    .wdogTimeout(wdogTimeout), .resultOut(resultOut),
    .resultValid(resultValid), .flagsOut(flagsOut),
    .indexedLitOffsetEn(litEn));

  // ------------------------------------------------------------
  // Compare, bus and op tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_word(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(logic w, logic [15:0] ad, logic [31:0] wd,
                     logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= ad; pwdata <= wd; pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: no bus answer", $time);
      wrap_up();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(logic [15:0] ad, logic [7:0] exp);
    apb(1'b0, ad, 32'h0, 4'hF);
    chk_word(rd, {24'h0, exp});
  endtask

  function automatic logic [7:0] mF();
    return {1'b0, mW, mP, mA};
  endfunction

  task automatic op(asf_pkg::asf_kind_type k, logic [7:0] a, logic [7:0] b,
                    logic tf);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] bAdd;
    r = 8'h00;
    bAdd = (k == asf_pkg::ASF_K_SUB) ? ~b : b;
    case (k)
      asf_pkg::ASF_K_ADD, asf_pkg::ASF_K_SUB: begin
        s = {1'b0, a} + {1'b0, bAdd} + 9'(k == asf_pkg::ASF_K_SUB);
        h = {1'b0, a[3:0]} + {1'b0, bAdd[3:0]}
          + 5'(k == asf_pkg::ASF_K_SUB);
        r = s[7:0];
        mA[0] = s[8];
        mA[1] = h[4];
        mA[3] = (a[7] == bAdd[7]) && (r[7] != a[7]);
      end
      asf_pkg::ASF_K_AND: r = a & b;
      asf_pkg::ASF_K_IOR: r = a | b;
      asf_pkg::ASF_K_XOR: r = a ^ b;
      asf_pkg::ASF_K_RLC: begin
        r = {a[6:0], mA[0]};
        mA[0] = a[7];
      end
      asf_pkg::ASF_K_RRC: begin
        r = {mA[0], a[7:1]};
        mA[0] = a[0];
      end
      asf_pkg::ASF_K_KEEP: begin
        r = b;
        if (tf) mA = b[4:0];
      end
      asf_pkg::ASF_K_WDCLR: {mW, mP} = 2'b11;
      asf_pkg::ASF_K_SLEEP: {mW, mP} = 2'b10;
      asf_pkg::ASF_K_CALL: cp = '{mF(), workReg, bankSel};
      default: r = 8'h00;
    endcase
    if (k >= asf_pkg::ASF_K_ADD && k <= asf_pkg::ASF_K_CLR) begin
      mA[2] = (r == 8'h00);
      if (k != asf_pkg::ASF_K_CLR) mA[4] = r[7];
    end
    @(posedge clk);
    opIn <= '{1'b1, k, a, b, tf};
    @(posedge clk);
    opIn.valid <= 1'b0;
    #1;
    chk_byte(flagsOut, mF());
    if (k >= asf_pkg::ASF_K_ADD && k <= asf_pkg::ASF_K_KEEP && !tf) begin
      chk_byte({7'h0, resultValid}, 8'h01);
      chk_byte(resultOut, r);
    end else begin
      chk_byte({7'h0, resultValid}, 8'h00);
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cpAdr = '{asf_pkg::ASF_ADR_FLAGS_COPY, asf_pkg::ASF_ADR_WORK_COPY,
              asf_pkg::ASF_ADR_BANK_COPY};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk_byte(flagsOut, 8'h60);
    rdchk(asf_pkg::ASF_ADR_FLAG_REG, 8'h60);
    rdchk(asf_pkg::ASF_ADR_CTRL, 8'h00);
    rdchk(16'hE20C, 8'h00);
    for (int i = 0; i < 3; i++) rdchk(cpAdr[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      op(asf_pkg::ASF_K_ADD, va[i], vb[i], 1'b0);
      op(asf_pkg::ASF_K_SUB, va[i], vb[i], 1'b0);
    end
    for (int i = 0; i < 20; i++) begin
      rnd = lfsr(rnd);
      op(i[0] ? asf_pkg::ASF_K_SUB : asf_pkg::ASF_K_ADD, rnd,
         lfsr(rnd), 1'b0);
    end
    op(asf_pkg::ASF_K_AND, 8'hF0, 8'h0F, 1'b0);
    op(asf_pkg::ASF_K_IOR, 8'h80, 8'h01, 1'b0);
    op(asf_pkg::ASF_K_XOR, 8'h5A, 8'h5A, 1'b0);
    op(asf_pkg::ASF_K_RLC, 8'h81, 8'h00, 1'b0);
    op(asf_pkg::ASF_K_RRC, 8'h01, 8'h00, 1'b0);
    op(asf_pkg::ASF_K_NOP, 8'h12, 8'h34, 1'b0);
    op(asf_pkg::ASF_K_ADD, 8'hFF, 8'h01, 1'b1);
    op(asf_pkg::ASF_K_KEEP, 8'h00, 8'h1A, 1'b1);
    op(asf_pkg::ASF_K_CLR, 8'h00, 8'h00, 1'b1);
    op(asf_pkg::ASF_K_KEEP, 8'h00, 8'h00, 1'b0);
    op(asf_pkg::ASF_K_CALL, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 3; i++) rdchk(cpAdr[i], cp[i]);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, cpAdr[i], {24'h0, 8'hC3 ^ 8'(i)}, 4'hF);
      cp[i] = 8'hC3 ^ 8'(i);
    end
    op(asf_pkg::ASF_K_ADD, 8'h11, 8'h22, 1'b0);
    for (int i = 0; i < 3; i++) rdchk(cpAdr[i], cp[i]);
    op(asf_pkg::ASF_K_SLEEP, 8'h00, 8'h00, 1'b0);
    @(posedge clk);
    wdogTimeout <= 1'b1;
    @(posedge clk);
    wdogTimeout <= 1'b0;
    mW = 1'b0;
    #1;
    chk_byte(flagsOut, mF());
    op(asf_pkg::ASF_K_WDCLR, 8'h00, 8'h00, 1'b0);
    apb(1'b1, asf_pkg::ASF_ADR_FLAG_REG, 32'h0000_0095, 4'hF);
    mA = 5'h15;
    rdchk(asf_pkg::ASF_ADR_FLAG_REG, mF());
    apb(1'b1, asf_pkg::ASF_ADR_CTRL, 32'h0000_0001, 4'h0);
    #1;
    chk_byte({7'h0, litEn}, 8'h00);
    apb(1'b1, asf_pkg::ASF_ADR_CTRL, 32'h0000_0001, 4'hF);
    @(posedge clk);
    #1;
    chk_byte({7'h0, litEn}, 8'h01);
    rdchk(asf_pkg::ASF_ADR_CTRL, 8'h01);
    chk_byte({7'h0, pslverr}, 8'h00);
    wrap_up();
  end
endmodule // tb
